// ===== logic/tsp_pkg.sv
// Purpose: Constants and carrier types for the timing pin I/O block
// Assumes: One 40 MHz core clock, synchronous active-low reset
// Notes:   Pin index constants name which internal signal each function pin carries
// Overview of operation
// - One conversion pulse per conversion when enabled
// - Conversion pulse rising edge frees the input
// - Software-controlled strobe output level
// - Pin zero input: timing input or analog trigger
// - Pin zero drives first trigger in posttrigger
// - First trigger rise starts pretrigger conversions
// - Pin one drives second trigger in pretrigger
// - Second trigger idle in posttrigger-only mode
// - Pin two drives active-low convert strobe
// - Pins three, eight echo counter sources
// - Pins four, nine echo counter gates
// - Dedicated pins carry both counter outputs
// - Pin five drives active-low update strobe
// - Pin six drives waveform start trigger
// - Pin seven pulses at each scan start
// - Scan pulse rise follows scan start by one cycle
// - Dedicated pin carries frequency generator output
// - Input-configured pins accept external timing signals
// - Digital lines six, seven steer count direction
package tsp_pkg;

    localparam int unsigned NUM_PINS = 10;

    // Function pin positions
    localparam int unsigned PIN_FIRST_TRIG  = 0;
    localparam int unsigned PIN_SECOND_TRIG = 1;
    localparam int unsigned PIN_CONVERT     = 2;
    localparam int unsigned PIN_B_SOURCE    = 3;
    localparam int unsigned PIN_B_GATE      = 4;
    localparam int unsigned PIN_UPDATE      = 5;
    localparam int unsigned PIN_WAVE_TRIG   = 6;
    localparam int unsigned PIN_SCAN_BEGIN  = 7;
    localparam int unsigned PIN_A_SOURCE    = 8;
    localparam int unsigned PIN_A_GATE      = 9;

    // Reset levels of outward signals
    localparam logic       IDLE_HIGH = 1'b1;
    localparam logic       IDLE_LOW  = 1'b0;
    localparam logic [9:0] PINS_ZERO = 10'h000;
    localparam logic [9:0] PINS_ONES = 10'h3FF;
    // Active-low strobes idle high: convert (bit 2) and update (bit 5)
    localparam logic [9:0] PINS_IDLE = 10'h024;

    // Internal timing signals from the engines
    typedef struct packed {
        logic first_trigger;
        logic second_trigger;
        logic convert_n;
        logic update_n;
        logic waveform_start_trigger;
        logic scan_begin_pulse;
        logic conversion_pulse;
        logic counter_a_source;
        logic counter_a_gate;
        logic counter_a_output;
        logic counter_b_source;
        logic counter_b_gate;
        logic counter_b_output;
        logic freq_generator_output;
    } tsp_internal_t;

    // Mode and enable settings from the owning logic
    typedef struct packed {
        logic [9:0] pin_drive;
        logic       conversion_pulse_en;
        logic       pretrigger_mode;
        logic       software_strobe_level;
        logic       pin_zero_analog_trig;
    } tsp_config_t;

    // Dedicated output pins
    typedef struct packed {
        logic conversion_pulse_out;
        logic software_strobe_n;
        logic counter_a_output;
        logic counter_b_output;
        logic freq_generator_output;
    } tsp_dedicated_t;

    // Externally received timing signals toward the engines
    typedef struct packed {
        logic [9:0] pin_timing_in;
        logic       analog_trig_source;
        logic       counter_a_up;
        logic       counter_b_up;
    } tsp_received_t;

    // Whole module state
    typedef struct packed {
        logic [9:0]     pin_s1;
        logic [9:0]     pin_s2;
        logic [9:0]     pin_s3;
        logic [9:0]     pin_in;
        logic [1:0]     dio_s1;
        logic [1:0]     dio_s2;
        logic [1:0]     dio_s3;
        logic [1:0]     dio_in;
        logic [9:0]     pin_out;
        logic [9:0]     pin_oe_n;
        tsp_dedicated_t ded;
    } tsp_state_t;

endpackage : tsp_pkg

// ===== logic/tsp_timing_pins.sv
// Purpose: Routes internal timing signals to the function pins and receives external ones
// Assumes: Engine signals are synchronous to core_clk_i; pins and digital lines are not
// Notes:   Every pin output is registered, adding one cycle of latency to all edges
`timescale 1ns/10ps
`default_nettype none
module tsp_timing_pins
    import tsp_pkg::*;
(
    // Clock and reset
    input  wire logic           core_clk_i,
    input  wire logic           rst_n_i,
    // Engine side
    input  var  tsp_internal_t  internal_i,
    input  var  tsp_config_t    config_i,
    output var  tsp_received_t  received_o,
    // Function pins, three-signal form
    input  wire logic [9:0]     pin_in_i,
    output logic      [9:0]     pin_out_o,
    output logic      [9:0]     pin_oe_n_o,
    // Digital lines six and seven
    input  wire logic           digital_line_six_i,
    input  wire logic           digital_line_seven_i,
    // Dedicated output pins
    output var  tsp_dedicated_t dedicated_o
);

    tsp_state_t state_r;
    tsp_state_t state_nxt;
    logic [9:0] route;

    // Glitch filter: a new level counts only once the later two sync stages agree
    function automatic logic sync_agree(input logic held, input logic s2, input logic s3);
        sync_agree = (s2 == s3) ? s3 : held;
    endfunction : sync_agree

    // Internal signal assigned to each function pin
    always_comb begin
        route                  = PINS_ZERO;
        route[PIN_FIRST_TRIG]  = internal_i.first_trigger;
        // Second trigger only carries events in pretrigger runs
        route[PIN_SECOND_TRIG] = internal_i.second_trigger & config_i.pretrigger_mode;
        route[PIN_CONVERT]     = internal_i.convert_n;
        route[PIN_B_SOURCE]    = internal_i.counter_b_source;
        route[PIN_B_GATE]      = internal_i.counter_b_gate;
        route[PIN_UPDATE]      = internal_i.update_n;
        route[PIN_WAVE_TRIG]   = internal_i.waveform_start_trigger;
        // Passed straight to the pin register, so its rise follows the scan start by one cycle
        route[PIN_SCAN_BEGIN]  = internal_i.scan_begin_pulse;
        route[PIN_A_SOURCE]    = internal_i.counter_a_source;
        route[PIN_A_GATE]      = internal_i.counter_a_gate;
    end

    // Next-state: synchronisers, pin drive and dedicated outputs
    always_comb begin
        state_nxt        = state_r;
        state_nxt.pin_s1 = pin_in_i;
        state_nxt.pin_s2 = state_r.pin_s1;
        state_nxt.pin_s3 = state_r.pin_s2;
        // Accept a change only when the second and third stages agree, filtering a one-cycle glitch
        for (int i = 0; i < NUM_PINS; i++) begin
            state_nxt.pin_in[i] = sync_agree(state_r.pin_in[i], state_r.pin_s2[i],
                                             state_r.pin_s3[i]);
        end
        state_nxt.dio_s1 = {digital_line_seven_i, digital_line_six_i};
        state_nxt.dio_s2 = state_r.dio_s1;
        state_nxt.dio_s3 = state_r.dio_s2;
        for (int j = 0; j < 2; j++) begin
            state_nxt.dio_in[j] = sync_agree(state_r.dio_in[j], state_r.dio_s2[j],
                                             state_r.dio_s3[j]);
        end
        // Undriven pins still register the routed value so a turn-on shows no stale level
        state_nxt.pin_out  = route;
        state_nxt.pin_oe_n = ~config_i.pin_drive;
        state_nxt.ded.conversion_pulse_out  = internal_i.conversion_pulse
                                            & config_i.conversion_pulse_en;
        state_nxt.ded.software_strobe_n     = ~config_i.software_strobe_level;
        state_nxt.ded.counter_a_output      = internal_i.counter_a_output;
        state_nxt.ded.counter_b_output      = internal_i.counter_b_output;
        state_nxt.ded.freq_generator_output = internal_i.freq_generator_output;
    end

    // State register with synchronous reset
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            state_r.pin_s1   <= PINS_ONES;
            state_r.pin_s2   <= PINS_ONES;
            state_r.pin_s3   <= PINS_ONES;
            state_r.pin_in   <= PINS_ONES;
            state_r.dio_s1   <= 2'h0;
            state_r.dio_s2   <= 2'h0;
            state_r.dio_s3   <= 2'h0;
            state_r.dio_in   <= 2'h0;
            state_r.pin_out  <= PINS_IDLE;
            state_r.pin_oe_n <= PINS_ONES;
            state_r.ded.conversion_pulse_out  <= IDLE_LOW;
            state_r.ded.software_strobe_n     <= IDLE_HIGH;
            state_r.ded.counter_a_output      <= IDLE_LOW;
            state_r.ded.counter_b_output      <= IDLE_LOW;
            state_r.ded.freq_generator_output <= IDLE_LOW;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Outputs straight from flip-flops
    assign pin_out_o   = state_r.pin_out;
    assign pin_oe_n_o  = state_r.pin_oe_n;
    assign dedicated_o = state_r.ded;

    // Received signals; a pin the module drives reports nothing external
    always_comb begin
        received_o.pin_timing_in      = state_r.pin_in & state_r.pin_oe_n;
        received_o.analog_trig_source = state_r.pin_in[PIN_FIRST_TRIG] & state_r.pin_oe_n[PIN_FIRST_TRIG]
                                      & config_i.pin_zero_analog_trig;
        received_o.counter_a_up       = state_r.dio_in[0];
        received_o.counter_b_up       = state_r.dio_in[1];
    end

endmodule : tsp_timing_pins
`default_nettype wire

// ===== test/testbench.sv
// Purpose: Self-checking bench for the timing pins
// Assumes: 40 MHz clock, reset held 8 cycles
// Notes:   Waits cover output and input delays
`timescale 1ns/10ps
`default_nettype none
module testbench
    import tsp_pkg::*;
;
    // Stimulus, observation and counters
    logic           clk = 1'b0, rst_n = 1'b0, d6 = 1'b0, d7 = 1'b0;
    logic [9:0]     po, poe, lvl, ext_en = 10'h000, ext_v = 10'h000;
    tsp_internal_t  in_s = '0;
    tsp_config_t    cfg = '0;
    tsp_received_t  rx;
    tsp_dedicated_t ded;
    int             n_errors = 0, tests_run = 0, cyc = 0;
    tsp_timing_pins u_tsp_timing_pins (.core_clk_i(clk), .rst_n_i(rst_n), .internal_i(in_s), .config_i(cfg),
        .received_o(rx), .pin_in_i(lvl), .pin_out_o(po), .pin_oe_n_o(poe), .digital_line_six_i(d6),
        .digital_line_seven_i(d7), .dedicated_o(ded));
    tsp_ext_equipment u_tsp_ext_equipment (.pin_out_i(po), .pin_oe_n_i(poe), .ext_en_i(ext_en),
        .ext_val_i(ext_v), .pin_level_o(lvl));
    initial forever #12.5 clk = ~clk;
    // A hang counts as a mismatch
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) finish_test(1'b1);
    end
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic finish_test(input bit hang);
        n_errors += hang;
        if (n_errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : finish_test
    // Alternating patterns give every pin both edges
    task automatic t_routing;
        logic [13:0]   pats [4] = '{14'h3FFF, 14'h2AAA, 14'h1555, 14'h0000};
        tsp_internal_t s;
        for (int k = 0; k < 8; k++) begin
            s = tsp_internal_t'(pats[k % 4]);
            @(posedge clk);
            in_s <= s;
            cfg  <= '{10'h3FF, k[0], k < 4, k[1], 1'b0};
            @(posedge clk);
            #1 check({poe, po}, {10'h000, s.counter_a_gate, s.counter_a_source, s.scan_begin_pulse,
                s.waveform_start_trigger, s.update_n, s.counter_b_gate, s.counter_b_source, s.convert_n,
                s.second_trigger & (k < 4), s.first_trigger});
            check(ded, {s.conversion_pulse & k[0], !k[1], s.counter_a_output, s.counter_b_output,
                s.freq_generator_output});
        end
    endtask : t_routing
    task automatic t_reset;
        @(posedge clk) rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        #1 check({poe, po}, {PINS_ONES, PINS_IDLE});
        check(ded, 5'h08);
        @(posedge clk) rst_n <= 1'b1;
    endtask : t_reset
    // A one-cycle dip on pin 3 must not reach the engines
    task automatic t_inputs;
        // Driven pins sit high so the input mask on them is really exercised
        @(posedge clk) cfg <= '{10'h0F0, 1'b0, 1'b0, 1'b0, 1'b1};
        in_s   <= '1;
        ext_en <= 10'h3FF;
        ext_v  <= 10'h30A;
        d6     <= 1'b1;
        repeat (6) @(posedge clk);
        ext_v <= 10'h302;
        @(posedge clk) ext_v <= 10'h30A;
        repeat (6) @(posedge clk) #1 check(rx, {10'h30A, 3'b010});
        @(posedge clk) ext_en <= 10'h000;
        d6 <= 1'b0;
        d7 <= 1'b1;
        repeat (6) @(posedge clk);
        #1 check(rx, {10'h30F, 3'b101});
        // Pin zero as a plain timing input must not feed the analog trigger
        cfg.pin_zero_analog_trig <= 1'b0;
        @(posedge clk) #1 check(rx, {10'h30F, 3'b001});
    endtask : t_inputs
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        t_routing();
        t_reset();
        t_inputs();
        finish_test(1'b0);
    end
endmodule : testbench
`default_nettype wire

// ===== test/tsp_ext_equipment.sv
// Purpose: Equipment on the connector side of the pins
// Assumes: Every pin has a pull-up
// Notes:   A released pin reads high, never the last value
`timescale 1ns/10ps
`default_nettype none
module tsp_ext_equipment (
    input  wire logic [9:0] pin_out_i,
    input  wire logic [9:0] pin_oe_n_i,
    input  wire logic [9:0] ext_en_i,
    input  wire logic [9:0] ext_val_i,
    output logic      [9:0] pin_level_o
);
    // Device drive wins, then equipment, then pull-up
    assign pin_level_o = (~pin_oe_n_i & pin_out_i) | (pin_oe_n_i & (~ext_en_i | ext_val_i));
endmodule : tsp_ext_equipment
`default_nettype wire

// ===== test/tsp_properties.sv
// Purpose: Port relations of the timing pin block
// Assumes: One clock, sync active-low reset
// Notes:   Inputs need six stable samples
`timescale 1ns/10ps
`default_nettype none
module tsp_properties
    import tsp_pkg::*;
(
    // Watched ports
    input wire logic           core_clk_i,
    input wire logic           rst_n_i,
    input var  tsp_internal_t  internal_i,
    input var  tsp_config_t    config_i,
    input var  tsp_received_t  received_o,
    input wire logic [9:0]     pin_in_i,
    input wire logic [9:0]     pin_out_o,
    input wire logic [9:0]     pin_oe_n_o,
    input var  tsp_dedicated_t dedicated_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    // Outputs trail inputs one edge; past-reset guard skips the first edge
    a_ded_pins : assert property ($past(rst_n_i) |-> dedicated_o == $past({
        internal_i.conversion_pulse & config_i.conversion_pulse_en, !config_i.software_strobe_level,
        internal_i.counter_a_output, internal_i.counter_b_output, internal_i.freq_generator_output}))
        else $error("dedicated pins");
    a_second_gate : assert property ($past(rst_n_i) |-> pin_out_o[1] ==
        $past(internal_i.second_trigger & config_i.pretrigger_mode)) else $error("second trigger");
    a_convert_fall : assert property ($fell(internal_i.convert_n) |=> $fell(pin_out_o[2]))
        else $error("convert strobe");
    a_counter_pins : assert property ($past(rst_n_i) |-> {pin_out_o[9:8], pin_out_o[4:3]} == $past({
        internal_i.counter_a_gate, internal_i.counter_a_source, internal_i.counter_b_gate,
        internal_i.counter_b_source})) else $error("counter pins");
    a_trig_pins : assert property ($past(rst_n_i) |-> {pin_out_o[6:5], pin_out_o[0]} == $past({
        internal_i.waveform_start_trigger, internal_i.update_n, internal_i.first_trigger}))
        else $error("trigger pins");
    a_scan_rise : assert property ($rose(internal_i.scan_begin_pulse) |=> $rose(pin_out_o[7]))
        else $error("scan pulse");
    a_dir_select : assert property ($past(rst_n_i) |-> pin_oe_n_o == ~$past(config_i.pin_drive))
        else $error("pin direction");
    a_input_sync : assert property ((!config_i.pin_drive[2] && !pin_in_i[2])[*6] |->
        !received_o.pin_timing_in[2]) else $error("pin input");
    cover property ($rose(pin_out_o[0]));
    cover property ($fell(dedicated_o.software_strobe_n));
    cover property (!received_o.pin_timing_in[2]);
endmodule : tsp_properties
bind tsp_timing_pins tsp_properties u_tsp_properties (.*);
`default_nettype wire
